// ### common/ipz_pkg.sv
// constants and types for the priority assignment register zero block
package ipz_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] IPZ_BASE_ADDR = 16'hf0c0;
  localparam logic [15:0] IPZ_PRIO0_OFS = 16'h0000;
  localparam logic [15:0] IPZ_PRIO0_RST = 16'h0000;
  localparam logic [15:0] IPZ_RD_IDLE = 16'h0000;
  localparam int IPZ_NUM_SRC = 8;
  localparam int IPZ_FLD_W = 2;
  // ****************************************
  // source slots, field lsb is twice the slot
  // ****************************************
  localparam int IPZ_SRC_TMR = 7;
  localparam int IPZ_SRC_CLK = 6;
  localparam int IPZ_SRC_LVD = 5;
  localparam int IPZ_SRC_RXF = 4;
  localparam int IPZ_SRC_TXE = 3;
  localparam int IPZ_SRC_TRC = 2;
  localparam int IPZ_SRC_BKP = 1;
  localparam int IPZ_SRC_STP = 0;
  localparam int IPZ_TMR_LSB = 14;
  localparam int IPZ_CLK_LSB = 12;
  localparam int IPZ_LVD_LSB = 10;
  localparam int IPZ_RXF_LSB = 8;
  localparam int IPZ_TXE_LSB = 6;
  localparam int IPZ_TRC_LSB = 4;
  localparam int IPZ_BKP_LSB = 2;
  localparam int IPZ_STP_LSB = 0;
  // ****************************************
  // field codes and level offsets
  // ****************************************
  localparam logic [1:0] IPZ_CODE_OFF = 2'h0;
  localparam logic [1:0] IPZ_LVL_TOP = 2'h3;
  localparam logic [1:0] IPZ_TMR_LVL_OFS = 2'h1;
  localparam logic [1:0] IPZ_GEN_LVL_OFS = 2'h0;
  typedef enum logic [1:0] {
    IPZ_ST_RUN = 2'h1,
    IPZ_ST_SLEEP = 2'h2
  } ipz_pwr_t;
endpackage : ipz_pkg

// ### common/ipz_field_if.sv
// carrier between the register and one field decoder
`timescale 1ns/1ps
interface ipz_field_if (
  input logic clk,
  input logic rst
);
  logic [1:0] code;
  logic [1:0] level;
  logic en;
  modport dec (input clk, input rst, input code, output level, output en);
  modport top (output code, input level, input en);
endinterface : ipz_field_if

// ### src/ipz_field_decode.sv
// decoder from one two-bit priority code to a level and an enable
`timescale 1ns/1ps
module ipz_field_decode #(
  parameter logic [1:0] LVL_OFS = 2'h0
) (
  ipz_field_if.dec fld
);
  // ****************************************
  // decode
  // ****************************************
  // code 00 means off; other codes shift down by the class offset
  assign fld.en = (fld.code != ipz_pkg::IPZ_CODE_OFF); // RL14
  // a disabled field reports level zero so the timer never shows the top level
  assign fld.level = fld.en ? 2'(fld.code - LVL_OFS) : '0; // RL4 RL5

  // ****************************************
  // checks
  // ****************************************
  a_off_disables: assert property ( // RL14
    @(posedge fld.clk) disable iff (fld.rst)
    (fld.code == ipz_pkg::IPZ_CODE_OFF) |-> !fld.en)
    else $error("code 00 left source enabled");

  a_level_map: assert property ( // RL4
    @(posedge fld.clk) disable iff (fld.rst)
    fld.en |-> (fld.level + LVL_OFS == fld.code))
    else $error("level does not match code");
endmodule : ipz_field_decode

// ### src/ipz_prio_zero.sv
// priority assignment register zero with decode and wake gating
//
// Overview of operation
// (RL1) register sits at offset zero, decoded at the controller base address
// (RL2) reset clears all sixteen bits, every source disabled
// (RL3) bits 15..14 hold second timer channel 3 priority
// (RL4) timer field: 01 is level 0, 10 level 1, 11 level 2
// (RL5) other fields: 01 is level 1, 10 level 2, 11 level 3
// (RL6) bits 13..12 hold clock and pll event priority
// (RL7) bits 11..10 hold low voltage detector priority
// (RL8) bits 9..8 hold debug receive full priority
// (RL9) bits 7..6 hold debug transmit empty priority
// (RL10) bits 5..4 hold debug trace buffer priority
// (RL11) bits 3..2 hold debug breakpoint priority
// (RL12) bits 1..0 hold debug step counter priority
// (RL13) wake from low power only for sources enabled before entry
// (RL14) reads return last written value; code 00 blocks the source
// (RL15) decoded levels reach arbitration every cycle, new write next evaluation
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module ipz_prio_zero (
  input logic CLK,
  input logic RST,
  input logic CE,
  input logic [15:0] ADDR,
  input logic [15:0] WDATA,
  input logic WR,
  input logic RD,
  output logic [15:0] RDATA,
  input logic [7:0] SRC_REQ,
  input logic LOW_POWER,
  output logic [15:0] PRIO_LEVEL,
  output logic [7:0] PRIO_EN,
  output logic [7:0] ARB_REQ,
  output logic WAKE
);
  // ****************************************
  // declarations
  // ****************************************
  localparam logic [15:0] PRIO0_ADDR = 16'(ipz_pkg::IPZ_BASE_ADDR + ipz_pkg::IPZ_PRIO0_OFS);
  localparam int NSRC = ipz_pkg::IPZ_NUM_SRC;
  localparam int FW = ipz_pkg::IPZ_FLD_W;

  logic hit;
  logic [15:0] prio_r;
  logic [15:0] prio_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] level_r;
  logic [15:0] level_nxt;
  logic [7:0] en_r;
  logic [7:0] en_nxt;
  logic [7:0] arb_r;
  logic [7:0] arb_nxt;
  logic [7:0] snap_r;
  logic [7:0] snap_nxt;
  logic wake_r;
  logic wake_nxt;
  logic wake_cause;
  ipz_pkg::ipz_pwr_t state_r;
  ipz_pkg::ipz_pwr_t state_nxt;
  logic [1:0] code_nxt [NSRC];
  logic [1:0] dec_lvl [NSRC];
  logic [7:0] dec_en;

  // ****************************************
  // register access
  // ****************************************
  // full address compare: the block answers only at base plus offset
  assign hit = (ADDR == PRIO0_ADDR); // RL1

  always_comb begin
    prio_nxt = prio_r;
    rdata_nxt = ipz_pkg::IPZ_RD_IDLE;
    if (WR && hit) begin
      prio_nxt = WDATA; // RL14
    end
    // read data stand for one cycle only, idle value otherwise
    if (RD && hit) begin
      rdata_nxt = prio_r; // RL14
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prio_r <= ipz_pkg::IPZ_PRIO0_RST; // RL2
      rdata_r <= ipz_pkg::IPZ_RD_IDLE;
    end else if (CE) begin
      prio_r <= prio_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // field map
  // ****************************************
  // decoders look at the next value so outputs move with the register
  assign code_nxt[ipz_pkg::IPZ_SRC_TMR] = prio_nxt[ipz_pkg::IPZ_TMR_LSB +: FW]; // RL3
  assign code_nxt[ipz_pkg::IPZ_SRC_CLK] = prio_nxt[ipz_pkg::IPZ_CLK_LSB +: FW]; // RL6
  assign code_nxt[ipz_pkg::IPZ_SRC_LVD] = prio_nxt[ipz_pkg::IPZ_LVD_LSB +: FW]; // RL7
  assign code_nxt[ipz_pkg::IPZ_SRC_RXF] = prio_nxt[ipz_pkg::IPZ_RXF_LSB +: FW]; // RL8
  assign code_nxt[ipz_pkg::IPZ_SRC_TXE] = prio_nxt[ipz_pkg::IPZ_TXE_LSB +: FW]; // RL9
  assign code_nxt[ipz_pkg::IPZ_SRC_TRC] = prio_nxt[ipz_pkg::IPZ_TRC_LSB +: FW]; // RL10
  assign code_nxt[ipz_pkg::IPZ_SRC_BKP] = prio_nxt[ipz_pkg::IPZ_BKP_LSB +: FW]; // RL11
  assign code_nxt[ipz_pkg::IPZ_SRC_STP] = prio_nxt[ipz_pkg::IPZ_STP_LSB +: FW]; // RL12

  // ****************************************
  // field decoders
  // ****************************************
  ipz_field_if fld_if [NSRC] (.clk(CLK), .rst(RST));

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_dec
      // the timer field is one level lower than the rest
      localparam logic [1:0] OFS = (gi == ipz_pkg::IPZ_SRC_TMR) ?
        ipz_pkg::IPZ_TMR_LVL_OFS : ipz_pkg::IPZ_GEN_LVL_OFS; // RL4 RL5
      assign fld_if[gi].code = code_nxt[gi];
      assign dec_lvl[gi] = fld_if[gi].level;
      assign dec_en[gi] = fld_if[gi].en;
      ipz_field_decode #(
        .LVL_OFS(OFS)
      ) u_dec (
        .fld(fld_if[gi])
      );
    end
  endgenerate

  // ****************************************
  // arbitration feed
  // ****************************************
  always_comb begin
    level_nxt = '0;
    for (int i = 0; i < NSRC; i++) begin
      level_nxt[i*FW +: FW] = dec_lvl[i]; // RL15
    end
    en_nxt = dec_en;
    // disabled sources never reach arbitration
    arb_nxt = SRC_REQ & dec_en; // RL14 RL15
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      level_r <= '0;
      en_r <= '0;
      arb_r <= '0;
    end else if (CE) begin
      level_r <= level_nxt;
      en_r <= en_nxt;
      arb_r <= arb_nxt;
    end
  end

  // ****************************************
  // low power wake gating
  // ****************************************
  // the core is stopped in low power, so the enables are frozen at entry;
  // a write slipping in while asleep cannot arm a new wake source
  assign wake_cause = |(SRC_REQ & snap_r);

  always_comb begin
    state_nxt = state_r;
    snap_nxt = snap_r;
    wake_nxt = 1'b0;
    case (state_r)
      ipz_pkg::IPZ_ST_RUN: begin
        snap_nxt = en_r; // RL13
        if (LOW_POWER) begin
          state_nxt = ipz_pkg::IPZ_ST_SLEEP;
        end
      end
      ipz_pkg::IPZ_ST_SLEEP: begin
        if (!LOW_POWER) begin
          state_nxt = ipz_pkg::IPZ_ST_RUN;
        end else begin
          wake_nxt = wake_cause; // RL13
        end
      end
      default: begin
        state_nxt = ipz_pkg::IPZ_ST_RUN;
        snap_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= ipz_pkg::IPZ_ST_RUN;
      snap_r <= '0;
      wake_r <= 1'b0;
    end else if (CE) begin
      state_r <= state_nxt;
      snap_r <= snap_nxt;
      wake_r <= wake_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign RDATA = rdata_r;
  assign PRIO_LEVEL = level_r;
  assign PRIO_EN = en_r;
  assign ARB_REQ = arb_r;
  assign WAKE = wake_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  logic [1:0] tmr_code;
  logic [1:0] tmr_lvl;
  assign tmr_code = prio_r[ipz_pkg::IPZ_TMR_LSB +: FW];
  assign tmr_lvl = PRIO_LEVEL[ipz_pkg::IPZ_TMR_LSB +: FW];

  a_reset_clear: assert property ( // RL2
    @(posedge CLK) disable iff (1'b0)
    RST |-> (prio_r == ipz_pkg::IPZ_PRIO0_RST && PRIO_EN == '0 && !WAKE))
    else $error("register not cleared in reset");

  a_write_stores: assert property ( // RL1
    (CE && WR && ADDR == PRIO0_ADDR) |=> (prio_r == $past(WDATA)))
    else $error("write at register address not stored");

  a_miss_ignored: assert property ( // RL1
    (CE && WR && ADDR != PRIO0_ADDR) |=> $stable(prio_r))
    else $error("write at other address changed register");

  sequence s_write;
    CE && WR && hit;
  endsequence

  sequence s_read;
    CE && RD && hit && !WR;
  endsequence

  a_read_back: assert property ( // RL14
    s_write ##1 s_read |=> (RDATA == $past(WDATA, 2)))
    else $error("read did not return last written value");

  a_read_idle: assert property ( // RL14
    (CE && !(RD && hit)) |=> (RDATA == ipz_pkg::IPZ_RD_IDLE))
    else $error("read data held past its cycle");

  a_tmr_decode: assert property ( // RL3
    PRIO_EN[ipz_pkg::IPZ_SRC_TMR] |->
      (tmr_lvl == tmr_code - ipz_pkg::IPZ_TMR_LVL_OFS))
    else $error("timer field decoded wrongly");

  a_tmr_no_top: assert property ( // RL4
    tmr_lvl != ipz_pkg::IPZ_LVL_TOP)
    else $error("timer source reached top level");

  a_clk_decode: assert property ( // RL6
    PRIO_LEVEL[ipz_pkg::IPZ_CLK_LSB +: FW] == prio_r[ipz_pkg::IPZ_CLK_LSB +: FW])
    else $error("clock field decoded wrongly");

  a_gen_nonzero: assert property ( // RL5
    PRIO_EN[ipz_pkg::IPZ_SRC_LVD] |->
      (PRIO_LEVEL[ipz_pkg::IPZ_LVD_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("general source at level zero");

  a_dbg_fields: assert property ( // RL8
    PRIO_LEVEL[ipz_pkg::IPZ_STP_LSB +: 5 * FW] == prio_r[ipz_pkg::IPZ_STP_LSB +: 5 * FW])
    else $error("debug fields decoded wrongly");

  a_disabled_blocked: assert property ( // RL14
    (ARB_REQ & ~PRIO_EN) == '0)
    else $error("disabled source reached arbitration");

  a_req_follows: assert property ( // RL15
    CE |=> (ARB_REQ == ($past(SRC_REQ) & PRIO_EN)))
    else $error("arbitration feed not current");

  a_ce_freeze: assert property (
    !CE |=> ($stable(prio_r) && $stable(RDATA) && $stable(WAKE)))
    else $error("state moved with clock enable low");

  sequence s_enter_sleep;
    (CE && state_r == ipz_pkg::IPZ_ST_RUN && LOW_POWER) ##1
      (state_r == ipz_pkg::IPZ_ST_SLEEP);
  endsequence

  sequence s_sleep_req;
    CE && state_r == ipz_pkg::IPZ_ST_SLEEP && LOW_POWER && wake_cause;
  endsequence

  a_snap_entry: assert property ( // RL13
    s_enter_sleep |-> (snap_r == $past(en_r)))
    else $error("enables not frozen at low power entry");

  a_wake_raise: assert property ( // RL13
    s_sleep_req |=> WAKE)
    else $error("enabled pending source did not wake");

  a_wake_cause: assert property ( // RL13
    WAKE |-> ($past(wake_cause) && $past(LOW_POWER)))
    else $error("wake without armed pending source");

  a_wake_drop: assert property ( // RL13
    (CE && !LOW_POWER) |=> !WAKE)
    else $error("wake held outside low power");

  a_read_miss: assert property ( // RL1
    (CE && RD && !hit) |=> (RDATA == ipz_pkg::IPZ_RD_IDLE))
    else $error("read at other address returned data");

  // ****************************************
  // field position and enable checks
  // ****************************************
  a_tmr_en_map: assert property ( // RL3
    PRIO_EN[ipz_pkg::IPZ_SRC_TMR] ==
      (prio_r[ipz_pkg::IPZ_TMR_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("timer enable not taken from its field");

  a_clk_en_map: assert property ( // RL6
    PRIO_EN[ipz_pkg::IPZ_SRC_CLK] ==
      (prio_r[ipz_pkg::IPZ_CLK_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("clock enable not taken from its field");

  a_lvd_en_map: assert property ( // RL7
    PRIO_EN[ipz_pkg::IPZ_SRC_LVD] ==
      (prio_r[ipz_pkg::IPZ_LVD_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("low voltage enable not taken from its field");

  a_rxf_en_map: assert property ( // RL8
    PRIO_EN[ipz_pkg::IPZ_SRC_RXF] ==
      (prio_r[ipz_pkg::IPZ_RXF_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("receive full enable not taken from its field");

  a_txe_en_map: assert property ( // RL9
    PRIO_EN[ipz_pkg::IPZ_SRC_TXE] ==
      (prio_r[ipz_pkg::IPZ_TXE_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("transmit empty enable not taken from its field");

  a_trc_en_map: assert property ( // RL10
    PRIO_EN[ipz_pkg::IPZ_SRC_TRC] ==
      (prio_r[ipz_pkg::IPZ_TRC_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("trace enable not taken from its field");

  a_bkp_en_map: assert property ( // RL11
    PRIO_EN[ipz_pkg::IPZ_SRC_BKP] ==
      (prio_r[ipz_pkg::IPZ_BKP_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("breakpoint enable not taken from its field");

  a_stp_en_map: assert property ( // RL12
    PRIO_EN[ipz_pkg::IPZ_SRC_STP] ==
      (prio_r[ipz_pkg::IPZ_STP_LSB +: FW] != ipz_pkg::IPZ_CODE_OFF))
    else $error("step counter enable not taken from its field");
endmodule : ipz_prio_zero

// ### verification/ipz_core_model.sv
// core side bus master model for the priority register
`timescale 1ns/1ps
module ipz_core_model (
  input logic clk,
  output logic ce,
  output logic [15:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input logic [15:0] rdata
);
  initial begin
    ce = 1'b1;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ****************************************
  // bus cycles
  // ****************************************
  // every task starts and ends in the time step of a rising edge
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // released data shows no stale value
    wdata <= ~d;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    // read data stand only in the cycle after the strobe
    d = rdata;
  endtask : rd_reg
  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    wdata <= ~d;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    q = rdata;
  endtask : wr_rd
  // write attempt with the clock enable low, must leave no trace
  task automatic frz_wr(input logic [15:0] a, input logic [15:0] d);
    ce <= 1'b0;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
  endtask : frz_wr
endmodule : ipz_core_model

// ### verification/testbench.sv
// self-checking bench for the priority assignment register zero
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst;
  logic ce;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [7:0] src_req = 8'h00;
  logic low_power = 1'b0;
  logic [15:0] prio_level;
  logic [7:0] prio_en;
  logic [7:0] arb_req;
  logic wake;
  int error_cnt = 0;
  int num_checks = 0;
  localparam logic [15:0] BASE = 16'hf0c0;
  always #12.5 clk = ~clk;
  ipz_prio_zero dut_u (.CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SRC_REQ(src_req), .LOW_POWER(low_power),
    .PRIO_LEVEL(prio_level), .PRIO_EN(prio_en), .ARB_REQ(arb_req), .WAKE(wake));
  ipz_core_model core_u (.clk(clk), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  // ****************************************
  // checking and verdict
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // ****************************************
  // scenarios
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic t_reset;
    logic [15:0] d;
    core_u.rd_reg(BASE, d);
    chk(d, 16'h0000);
    chk({8'h00, prio_en}, 16'h0000);
    chk(prio_level, 16'h0000);
  endtask : t_reset
  task automatic t_decode;
    logic [15:0] v;
    logic [15:0] d;
    logic [1:0] lvl;
    for (int s = 0; s < 8; s++) begin
      for (int c = 1; c < 4; c++) begin
        v = 16'(c) << (2 * s);
        // timer slot sits one level lower
        lvl = (s == 7) ? 2'(c - 1) : 2'(c);
        core_u.wr_reg(BASE, v);
        chk(prio_level, 16'(lvl) << (2 * s));
        chk({8'h00, prio_en}, 16'h0001 << s);
        core_u.rd_reg(BASE, d);
        chk(d, v);
      end
    end
  endtask : t_decode
  task automatic t_unmapped;
    logic [15:0] d;
    core_u.wr_reg(BASE, 16'h8421);
    core_u.wr_reg(BASE + 16'h0001, 16'hffff);
    core_u.rd_reg(BASE + 16'h0001, d);
    chk(d, 16'h0000);
    core_u.rd_reg(BASE, d);
    chk(d, 16'h8421);
    chk(prio_level, 16'h4421);
  endtask : t_unmapped
  task automatic t_arb;
    src_req <= 8'hff;
    tick(2);
    chk({8'h00, arb_req}, 16'h00a5);
    src_req <= 8'h00;
    tick(1);
  endtask : t_arb
  task automatic t_wake;
    core_u.wr_reg(BASE, 16'h0001);
    low_power <= 1'b1;
    tick(2);
    // enabled only after entry, must not wake
    core_u.wr_reg(BASE, 16'h0005);
    src_req <= 8'h02;
    tick(3);
    chk({15'h0000, wake}, 16'h0000);
    chk({8'h00, arb_req}, 16'h0002);
    src_req <= 8'h01;
    tick(3);
    chk({15'h0000, wake}, 16'h0001);
    low_power <= 1'b0;
    src_req <= 8'h00;
    tick(3);
    chk({15'h0000, wake}, 16'h0000);
  endtask : t_wake
  task automatic t_freeze;
    logic [15:0] d;
    core_u.wr_rd(BASE, 16'h5a5a, d);
    chk(d, 16'h5a5a);
    core_u.frz_wr(BASE, 16'hffff);
    core_u.rd_reg(BASE, d);
    chk(d, 16'h5a5a);
    chk(prio_level, 16'h1a5a);
    chk({8'h00, prio_en}, 16'h00ff);
  endtask : t_freeze
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_decode();
    t_unmapped();
    t_arb();
    t_wake();
    t_freeze();
    final_report();
  end
  initial begin
    #100us;
    error_cnt++;
    final_report();
  end
endmodule : testbench
